// ==== rtl/etwc_timer.sv ====
// Functional notes
// - selected timer clock is an enable pulse
// - force strobe applies match action outside PWM
// - forced compare sets no flag, no clear
// - force strobe reads as zero, stores nothing
// - mode bits split: bit 3 high, bit 6
// - top per mode; compare buffered in PWM
// - overflow at MAX, or BOTTOM in phase PWM
// - nonzero output mode overrides normal pin function
// - non-PWM output: off, toggle, clear, set
// - fast PWM: clear/set on match, opposite top
// - phase PWM: action depends on count direction
// - compare equal top: act at top only
// - clock select: stop, 1, 8 ... 1024
// - counter register is read/write by software
// - counter write blocks next timer clock match
// - compare register compared with counter continuously
// - clear-on-match counts to compare then zero
// - fast PWM counts to MAX then clears
// - phase PWM holds MAX once, counts down
// - async select picks external oscillator source
//
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
module etwc_timer (
    input wire logic clk_i, // 50 MHz i/o clock
    input wire logic rst_i, // sync reset, high
    input wire logic wb_cyc_i, // bus cycle
    input wire logic wb_stb_i, // bus strobe
    input wire logic wb_we_i, // write enable
    input wire logic [etwc_pkg::WB_AW-1:0] wb_adr_i, // byte address
    input wire logic [3:0] wb_sel_i, // byte selects
    input wire logic [etwc_pkg::WB_DW-1:0] wb_dat_i, // write data
    output logic [etwc_pkg::WB_DW-1:0] wb_dat_o, // read data
    output logic wb_ack_o, // bus acknowledge
    input wire logic osc_i, // external oscillator pin
    input wire logic port_data_i, // normal port value
    output logic pin_o, // pin output level
    output logic pin_oe_o, // pin output enable
    output logic overflow_flag_o, // overflow flag
    output logic compare_match_flag_o // compare match flag
);
    import etwc_pkg::*;

    typedef struct packed {
        logic [6:0] ctrl;
        logic [7:0] cnt;
        logic [7:0] ocr;
        logic [7:0] ocr_buf;
        logic up;
        logic wave;
        logic blk;
        logic tov;
        logic ocf;
        logic async_sel;
        logic pin_dir;
        logic [PRESC_W-1:0] presc;
        logic osc_s1;
        logic osc_s2;
        logic osc_s3;
        logic ack;
        logic [WB_DW-1:0] dat;
        logic pin;
        logic pin_oe;
    } etwc_state_t;

    etwc_state_t r;
    etwc_state_t n;

    logic [1:0] wgm;
    logic [1:0] com;
    logic [2:0] cs;
    logic pwm;
    logic src;
    logic div_ok;
    logic tick;
    logic eq;
    logic match;
    logic ign;
    logic acc;
    logic wr;
    logic [7:0] wd;
    logic fwr;
    logic ovf_ev;

    assign wgm = {r.ctrl[CTL_WGM_HI_BIT], r.ctrl[CTL_WGM_LO_BIT]};
    assign com = r.ctrl[CTL_COM_HI_BIT:CTL_COM_LO_BIT];
    assign cs = r.ctrl[CTL_CS_HI_BIT:0];
    assign pwm = wgm[0];
    // oscillator edge from synchronised copies only
    assign src = r.async_sel ? (r.osc_s2 & ~r.osc_s3) : 1'b1;
    assign tick = src & div_ok;
    assign eq = (r.cnt == r.ocr);
    assign match = tick & eq & ~r.blk;
    assign ign = pwm & com[1] & (r.ocr == CNT_MAX);
    assign acc = wb_cyc_i & wb_stb_i & ~r.ack;
    assign wr = acc & wb_we_i & wb_sel_i[0];
    assign wd = wb_dat_i[7:0];
    assign fwr = wr & (wb_adr_i == ADDR_CONTROL) & wd[CTL_FORCE_BIT]
        & ~wd[CTL_WGM_LO_BIT];
    assign ovf_ev = tick & ((wgm == WGM_PHASE)
        ? (~r.up & (r.cnt == CNT_BOTTOM))
        : (r.cnt == CNT_MAX));

    always_comb begin
        case (cs)
            3'h0: div_ok = 1'b0;
            3'h1: div_ok = 1'b1;
            3'h2: div_ok = (r.presc & DIV8_MASK) == '0;
            3'h3: div_ok = (r.presc & DIV32_MASK) == '0;
            3'h4: div_ok = (r.presc & DIV64_MASK) == '0;
            3'h5: div_ok = (r.presc & DIV128_MASK) == '0;
            3'h6: div_ok = (r.presc & DIV256_MASK) == '0;
            default: div_ok = (r.presc & DIV1024_MASK) == '0;
        endcase
    end

    always_comb begin
        n = r;
        n.osc_s1 = osc_i;
        n.osc_s2 = r.osc_s1;
        n.osc_s3 = r.osc_s2;
        if (src) begin
            n.presc = r.presc + 1'b1;
        end
        n.ack = acc;

        // counting sequence per mode
        if (tick) begin
            n.blk = 1'b0;
            case (wgm)
                WGM_NORMAL: begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == CNT_MAX) begin
                        n.tov = 1'b1;
                    end
                end
                WGM_CLEAR: begin
                    if (match) begin
                        n.cnt = CNT_BOTTOM;
                    end else begin
                        n.cnt = r.cnt + 1'b1;
                    end
                    if (r.cnt == CNT_MAX) begin
                        n.tov = 1'b1;
                    end
                end
                WGM_FAST: begin
                    n.cnt = r.cnt + 1'b1;
                    if (r.cnt == CNT_MAX) begin
                        n.tov = 1'b1;
                        n.ocr = r.ocr_buf;
                    end
                end
                default: begin
                    if (r.up) begin
                        if (r.cnt == CNT_MAX) begin
                            n.up = 1'b0;
                            n.cnt = r.cnt - 1'b1;
                            n.ocr = r.ocr_buf;
                        end else begin
                            n.cnt = r.cnt + 1'b1;
                        end
                    end else if (r.cnt == CNT_BOTTOM) begin
                        n.up = 1'b1;
                        n.cnt = r.cnt + 1'b1;
                        n.tov = 1'b1;
                    end else begin
                        n.cnt = r.cnt - 1'b1;
                    end
                end
            endcase
        end

        // waveform on a real match
        if (match) begin
            n.ocf = 1'b1;
            if (!pwm) begin
                case (com)
                    COM_TOGGLE: n.wave = ~r.wave;
                    COM_CLEAR: n.wave = 1'b0;
                    COM_SET: n.wave = 1'b1;
                    default: n.wave = r.wave;
                endcase
            end else if (com[1] && !ign) begin
                if (wgm == WGM_FAST) begin
                    n.wave = com[0];
                end else begin
                    n.wave = r.up ? com[0] : ~com[0];
                end
            end
        end

        // action at top
        if (tick && pwm && com[1] && r.cnt == CNT_MAX) begin
            if (wgm == WGM_FAST) begin
                n.wave = ~com[0];
            end else if (ign && r.up) begin
                n.wave = ~com[0];
            end
        end

        // forced compare: output only
        if (fwr) begin
            case (wd[CTL_COM_HI_BIT:CTL_COM_LO_BIT])
                COM_TOGGLE: n.wave = ~r.wave;
                COM_CLEAR: n.wave = 1'b0;
                COM_SET: n.wave = 1'b1;
                default: n.wave = r.wave;
            endcase
        end

        // register writes
        if (wr) begin
            if (wb_adr_i == ADDR_CONTROL) begin
                n.ctrl = wd[6:0];
            end else if (wb_adr_i == ADDR_COUNT) begin
                n.cnt = wd;
                n.blk = 1'b1;
            end else if (wb_adr_i == ADDR_COMPARE) begin
                n.ocr_buf = wd;
            end else if (wb_adr_i == ADDR_FLAGS) begin
                // write one clears, a new event wins
                if (wd[FLG_OVERFLOW_BIT] && !ovf_ev) begin
                    n.tov = 1'b0;
                end
                if (wd[FLG_MATCH_BIT] && !match) begin
                    n.ocf = 1'b0;
                end
            end else if (wb_adr_i == ADDR_CONFIG) begin
                n.async_sel = wd[CFG_ASYNC_BIT];
                n.pin_dir = wd[CFG_PIN_DIR_BIT];
            end
        end
        if (!n.ctrl[CTL_WGM_LO_BIT]) begin
            n.ocr = n.ocr_buf;
        end

        // register reads
        n.dat = '0;
        if (acc && !wb_we_i) begin
            if (wb_adr_i == ADDR_CONTROL) begin
                n.dat[6:0] = r.ctrl;
            end else if (wb_adr_i == ADDR_COUNT) begin
                n.dat[7:0] = r.cnt;
            end else if (wb_adr_i == ADDR_COMPARE) begin
                n.dat[7:0] = r.ocr_buf;
            end else if (wb_adr_i == ADDR_FLAGS) begin
                n.dat[FLG_OVERFLOW_BIT] = r.tov;
                n.dat[FLG_MATCH_BIT] = r.ocf;
            end else if (wb_adr_i == ADDR_CONFIG) begin
                n.dat[CFG_ASYNC_BIT] = r.async_sel;
                n.dat[CFG_PIN_DIR_BIT] = r.pin_dir;
            end
        end

        // pin override when output mode nonzero
        if (n.ctrl[CTL_COM_HI_BIT:CTL_COM_LO_BIT] != COM_OFF) begin
            n.pin = n.wave;
        end else begin
            n.pin = port_data_i;
        end
        n.pin_oe = n.pin_dir;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            r <= '0;
            r.up <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o = r.dat;
    assign wb_ack_o = r.ack;
    assign pin_o = r.pin;
    assign pin_oe_o = r.pin_oe;
    assign overflow_flag_o = r.tov;
    assign compare_match_flag_o = r.ocf;

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    force_reads_zero_a: assert property (
        acc && !wb_we_i && wb_adr_i == ADDR_CONTROL |=> wb_ack_o
            && wb_dat_o[7] == 1'b0)
        else $error("force strobe read back nonzero");

    stopped_hold_a: assert property (
        cs == 3'h0 && !wr |=> r.cnt == $past(r.cnt))
        else $error("counter moved while stopped");

    clear_match_a: assert property (
        wgm == WGM_CLEAR && match && !wr |=> r.cnt == CNT_BOTTOM && r.ocf)
        else $error("clear-on-match did not clear");

    fast_wrap_a: assert property (
        wgm == WGM_FAST && tick && r.cnt == CNT_MAX && !wr
            |=> r.cnt == CNT_BOTTOM && r.tov)
        else $error("fast mode did not wrap");

    phase_top_a: assert property (
        wgm == WGM_PHASE && tick && r.up && r.cnt == CNT_MAX && !wr
            |=> !r.up && r.cnt == 8'hfe)
        else $error("phase mode did not reverse");

    force_no_flag_a: assert property (
        fwr && !match && !r.ocf |=> !r.ocf)
        else $error("forced compare set the flag");

    count_block_a: assert property (
        wr && wb_adr_i == ADDR_COUNT
            ##1 tick && eq && !wr && !r.ocf |=> !r.ocf)
        else $error("match after counter write");

    normal_ovf_a: assert property (
        wgm == WGM_NORMAL && tick && r.cnt == CNT_MAX |=> r.tov)
        else $error("overflow flag missed");

    ovf_set_wins_a: assert property (
        ovf_ev |=> overflow_flag_o)
        else $error("overflow event lost to a clear");

    phase_bottom_a: assert property (
        wgm == WGM_PHASE && tick && !r.up && r.cnt == CNT_BOTTOM && !wr
            |=> r.up && r.cnt == 8'h01 && r.tov)
        else $error("phase mode did not turn at bottom");

    force_no_clear_a: assert property (
        fwr && !tick |=> r.cnt == $past(r.cnt))
        else $error("forced compare moved the counter");

    bus_ack_a: assert property (
        acc |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not single cycle");

    pin_override_a: assert property (
        com != COM_OFF && !wr |=> pin_o == r.wave)
        else $error("pin not driven by waveform");

    clear_mode_c: cover property (wgm == WGM_CLEAR && match);
    phase_bottom_c: cover property (
        wgm == WGM_PHASE && tick && !r.up && r.cnt == CNT_BOTTOM);
    force_c: cover property (fwr && com == COM_TOGGLE);
    fast_pwm_c: cover property (wgm == WGM_FAST && match && com[1]);
endmodule : etwc_timer

// ==== rtl/etwc_pkg.sv ====
package etwc_pkg;
    // bus geometry
    localparam int WB_AW = 8;
    localparam int WB_DW = 32;

    // register byte offsets
    localparam logic [7:0] ADDR_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_COUNT = 8'h04;
    localparam logic [7:0] ADDR_COMPARE = 8'h08;
    localparam logic [7:0] ADDR_FLAGS = 8'h0c;
    localparam logic [7:0] ADDR_CONFIG = 8'h10;

    // timer_control field positions
    localparam int CTL_FORCE_BIT = 7;
    localparam int CTL_WGM_LO_BIT = 6;
    localparam int CTL_COM_HI_BIT = 5;
    localparam int CTL_COM_LO_BIT = 4;
    localparam int CTL_WGM_HI_BIT = 3;
    localparam int CTL_CS_HI_BIT = 2;

    // flag and config bit positions
    localparam int FLG_OVERFLOW_BIT = 0;
    localparam int FLG_MATCH_BIT = 1;
    localparam int CFG_ASYNC_BIT = 0;
    localparam int CFG_PIN_DIR_BIT = 1;

    // waveform modes, high bit first
    localparam logic [1:0] WGM_NORMAL = 2'h0;
    localparam logic [1:0] WGM_PHASE = 2'h1;
    localparam logic [1:0] WGM_CLEAR = 2'h2;
    localparam logic [1:0] WGM_FAST = 2'h3;

    // compare output modes
    localparam logic [1:0] COM_OFF = 2'h0;
    localparam logic [1:0] COM_TOGGLE = 2'h1;
    localparam logic [1:0] COM_CLEAR = 2'h2;
    localparam logic [1:0] COM_SET = 2'h3;

    // counter limits
    localparam logic [7:0] CNT_MAX = 8'hff;
    localparam logic [7:0] CNT_BOTTOM = 8'h00;

    // reset values
    localparam logic [7:0] CONTROL_RST = 8'h00;
    localparam logic [7:0] COUNT_RST = 8'h00;
    localparam logic [7:0] COMPARE_RST = 8'h00;

    // prescaler width and division masks per clock select code
    localparam int PRESC_W = 10;
    localparam logic [9:0] DIV8_MASK = 10'h007;
    localparam logic [9:0] DIV32_MASK = 10'h01f;
    localparam logic [9:0] DIV64_MASK = 10'h03f;
    localparam logic [9:0] DIV128_MASK = 10'h07f;
    localparam logic [9:0] DIV256_MASK = 10'h0ff;
    localparam logic [9:0] DIV1024_MASK = 10'h3ff;
endpackage : etwc_pkg

// ==== dv/eight_bit_timer_waveform_control_tb_top.sv ====
`timescale 1ns/1ps
module eight_bit_timer_waveform_control_tb_top;
    import etwc_pkg::*;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [WB_AW-1:0] wb_adr_i = '0;
    logic [WB_DW-1:0] wb_dat_i = '0;
    logic [WB_DW-1:0] wb_dat_o;
    logic wb_ack_o, pin_o, pin_oe_o, ovf_o, match_o;
    logic port_data_i = 1'b0;
    logic osc_i = 1'b0;
    int failures = 0;
    int tests_run = 0;
    int hi;
    int dv[8] = '{0, 1, 8, 32, 64, 128, 256, 1024};
    logic [7:0] rd, rd2;
    logic [1:0] fc[4] = '{COM_SET, COM_CLEAR, COM_TOGGLE, COM_TOGGLE};
    logic [7:0] fe[4] = '{8'h01, 8'h00, 8'h01, 8'h00};

    always #10 clk_i = ~clk_i;

    etwc_timer etwc_timer_i (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
        .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .osc_i(osc_i), .port_data_i(port_data_i),
        .pin_o(pin_o), .pin_oe_o(pin_oe_o), .overflow_flag_o(ovf_o),
        .compare_match_flag_o(match_o)
    );

    task automatic end_sim();
        if (failures == 0 && tests_run > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : end_sim

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            failures++;
            $display("BAD t=%0t got %h exp %h", $time, got, exp);
        end
    endtask : chk8

    task automatic chk_rng(input logic [15:0] got, input int lo, input int hi);
        logic ok;
        ok = (got >= lo && got <= hi);
        tests_run++;
        if (ok !== 1'b1) begin
            failures++;
            $display("BAD t=%0t got %0d not in %0d..%0d", $time, got, lo, hi);
        end
    endtask : chk_rng

    // one classic cycle, held until ack is sampled high
    task automatic bus(input logic we, input logic [7:0] a,
                       input logic [7:0] d, output logic [7:0] q);
        int n;
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        wb_dat_i <= {24'h0, d};
        for (n = 0; n < 16; n++) begin
            @(posedge clk_i);
            if (wb_ack_o === 1'b1) break;
        end
        q = wb_dat_o[7:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        if (n == 16) begin
            failures++;
            $display("BAD t=%0t bus timeout", $time);
            end_sim();
        end
    endtask : bus

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] q;
        bus(1'b1, a, d, q);
    endtask : wr

    task automatic rdr(input logic [7:0] a, output logic [7:0] q);
        bus(1'b0, a, 8'h00, q);
    endtask : rdr

    function automatic logic [7:0] ctl(input logic [1:0] m,
        input logic [1:0] c, input logic [2:0] cs, input logic f);
        return {f, m[0], c, m[1], cs};
    endfunction : ctl

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        rdr(ADDR_CONTROL, rd); chk8(rd, CONTROL_RST);
        rdr(ADDR_COUNT, rd); chk8(rd, COUNT_RST);
        rdr(ADDR_COMPARE, rd); chk8(rd, COMPARE_RST);
        wr(ADDR_CONTROL, 8'hb8);
        rdr(ADDR_CONTROL, rd); chk8(rd, 8'h38);
        wr(ADDR_CONTROL, 8'h48);
        rdr(ADDR_CONTROL, rd); chk8(rd, 8'h48);
        wr(8'h20, 8'hff);
        rdr(8'h20, rd); chk8(rd, 8'h00);
        wr(ADDR_COUNT, 8'h5a);
        rdr(ADDR_COUNT, rd); chk8(rd, 8'h5a);
        wr(ADDR_COMPARE, 8'ha5);
        rdr(ADDR_COMPARE, rd); chk8(rd, 8'ha5);
        // port value shows while output mode is off
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_CONFIG, 8'h02);
        rdr(ADDR_CONFIG, rd); chk8(rd, 8'h02);
        port_data_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        chk8({7'h0, pin_oe_o}, 8'h01);
        chk8({7'h0, pin_o}, 8'h01);
        // forced compare with count equal to compare, timer stopped
        wr(ADDR_COUNT, 8'h05);
        wr(ADDR_COMPARE, 8'h05);
        for (int i = 0; i < 4; i++) begin
            wr(ADDR_CONTROL, ctl(WGM_CLEAR, fc[i], 3'h0, 1'b1));
            repeat (2) @(posedge clk_i);
            chk8({7'h0, pin_o}, fe[i]);
        end
        rdr(ADDR_COUNT, rd); chk8(rd, 8'h05);
        chk8({7'h0, match_o}, 8'h00);
        // clear-on-match run
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_COMPARE, 8'h04);
        wr(ADDR_CONTROL, ctl(WGM_CLEAR, COM_OFF, 3'h1, 1'b0));
        repeat (40) @(posedge clk_i);
        wr(ADDR_CONTROL, 8'h00);
        rdr(ADDR_COUNT, rd); chk_rng({8'h0, rd}, 0, 4);
        chk8({7'h0, match_o}, 8'h01);
        chk8({7'h0, ovf_o}, 8'h00);
        // counter write suppresses the next match
        wr(ADDR_COMPARE, 8'h10);
        for (int i = 0; i < 2; i++) begin
            wr(ADDR_FLAGS, 8'h03);
            wr(ADDR_CONTROL, ctl(WGM_NORMAL, COM_OFF, 3'h1, 1'b0));
            wr(ADDR_COUNT, 8'h10 - 8'(i));
            repeat (4) @(posedge clk_i);
            chk8({7'h0, match_o}, 8'(i));
            wr(ADDR_CONTROL, 8'h00);
        end
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_COUNT, 8'hf0);
        wr(ADDR_CONTROL, ctl(WGM_NORMAL, COM_OFF, 3'h1, 1'b0));
        repeat (20) @(posedge clk_i);
        chk8({7'h0, ovf_o}, 8'h01);
        rdr(ADDR_FLAGS, rd); chk8(rd, 8'h01);
        // phase-correct turns at the top, overflows at the bottom
        wr(ADDR_CONTROL, 8'h00);
        wr(ADDR_FLAGS, 8'h03);
        wr(ADDR_COUNT, 8'hfc);
        wr(ADDR_CONTROL, ctl(WGM_PHASE, COM_OFF, 3'h1, 1'b0));
        repeat (8) @(posedge clk_i);
        wr(ADDR_CONTROL, 8'h00);
        rdr(ADDR_COUNT, rd); chk_rng({8'h0, rd}, 8'hf0, 8'hfe);
        chk8({7'h0, ovf_o}, 8'h00);
        wr(ADDR_CONTROL, ctl(WGM_PHASE, COM_OFF, 3'h1, 1'b0));
        repeat (520) @(posedge clk_i);
        chk8({7'h0, ovf_o}, 8'h01);
        // every prescaler code, four ticks each
        for (int cs = 1; cs < 8; cs++) begin
            wr(ADDR_CONTROL, 8'h00);
            wr(ADDR_COUNT, 8'h00);
            wr(ADDR_CONTROL, ctl(WGM_NORMAL, COM_OFF, 3'(cs), 1'b0));
            repeat (4 * dv[cs]) @(posedge clk_i);
            wr(ADDR_CONTROL, 8'h00);
            hi = (4 * dv[cs] + 3) / dv[cs];
            rdr(ADDR_COUNT, rd); chk_rng({8'h0, rd}, hi - 1, hi + 1);
        end
        repeat (20) @(posedge clk_i);
        rdr(ADDR_COUNT, rd2); chk8(rd2, rd);
        // fast pwm duty in both polarities
        wr(ADDR_COMPARE, 8'h40);
        for (int j = 0; j < 2; j++) begin
            wr(ADDR_COUNT, 8'hfe);
            wr(ADDR_CONTROL,
               ctl(WGM_FAST, j ? COM_SET : COM_CLEAR, 3'h1, 1'b0));
            repeat (8) @(posedge clk_i);
            hi = 0;
            repeat (512) begin
                @(posedge clk_i);
                if (pin_o === 1'b1) hi++;
            end
            wr(ADDR_CONTROL, 8'h00);
            chk_rng(16'(hi), j ? 376 : 124, j ? 388 : 136);
        end
        // oscillator edges as the timer source
        wr(ADDR_COUNT, 8'h00);
        wr(ADDR_CONFIG, 8'h03);
        wr(ADDR_CONTROL, ctl(WGM_NORMAL, COM_OFF, 3'h1, 1'b0));
        repeat (5) begin
            repeat (4) @(posedge clk_i);
            osc_i <= 1'b1;
            repeat (4) @(posedge clk_i);
            osc_i <= 1'b0;
        end
        repeat (4) @(posedge clk_i);
        wr(ADDR_CONTROL, 8'h00);
        rdr(ADDR_COUNT, rd); chk8(rd, 8'h05);
        end_sim();
    end
endmodule : eight_bit_timer_waveform_control_tb_top
